// *** rtl/pdsd_spi_diag.sv ***
// Serial control and diagnosis logic of the multi-output power driver
`timescale 1ns/100ps

// Behaviour
// - Warning flag high while any sensor reports warning temperature.
// - Warning flag not held; drops once no sensor reports warning.
// - Shutdown report sets the group shutdown flag and turns the group off.
// - Shutdown held until status reset request or power-on reset.
// - Group one is outputs one to three, group two outputs four to eleven.
// - Shutdown of one group leaves the other group running as commanded.
// - Sense codes 000/001 pick outputs 1/2, 010/011 pick 3/4, 100 picks 7.
// - Serial slave shifting in 16-bit control, shifting out status at once.
// - Serial data valid and sampled on the falling clock edge.
// - Frames move most significant bit first both ways.
// - Transfer starts when chip select falls; bits pass the shift register.
// - Chip select rise after 16 or more clocks commits the shift register as new control word.
// - Serial output released to high impedance while chip select high.
// - Shift path works in a daisy chain and with separate selects.
// - Frame is addressable data, address-independent data and 2-bit address.
// - Committed control word holds until replaced or power-on reset.
// - Chip select fall captures current diagnosis into the shift path.
// - Power-on reset clears stored state and puts outputs in high impedance.
// - Inhibit low stops the interface and outputs; its rise is a power-on reset.
// - Supply fail appears in bit 7 of the diagnosis word.
module pdsd_spi_diag
   import pdsd_pkg::*;
#(
   parameter int NUM_SENS = 4
) (
   // System clock and reset
   input  wire logic                clk_sys_i,
   input  wire logic                rst_b_i,
   // Serial link
   input  wire logic                sclk_i,
   input  wire logic                chip_select_n_i,
   input  wire logic                serial_in_i,
   output logic                     serial_out_o,
   output logic                     serial_out_oe_o,
   // Device pins and sensors
   input  wire logic                inhibit_input_i,
   input  wire logic [NUM_SENS-1:0] temp_warn_i,
   input  wire logic                temp_sd_grp1_i,
   input  wire logic                temp_sd_grp2_i,
   input  wire logic                supply_fail_i,
   // Power stage control
   output pdsd_drive_t              drive_o,
   output logic                     outputs_active_o,
   output pdsd_sense_t              sense_route_o,
   // Status
   output logic                     thermal_warning_flag_o,
   output logic [1:0]               thermal_shutdown_flag_o,
   output logic                     supply_fail_flag_o
);

   localparam int AW = NUM_SENS + 6;

   function automatic pdsd_sense_t sense_decode(input logic [2:0] code);
      pdsd_sense_t r;
      r     = '0;
      r.hs1 = (code == SENSE_HS1);
      r.hs2 = (code == SENSE_HS2);
      r.hs3 = (code == SENSE_HS3);
      r.hs4 = (code == SENSE_HS4);
      r.hs7 = (code == SENSE_HS7);
      return r;
   endfunction

   // Reset release
   logic rst_s1_q;
   logic rst_s2_q;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Link domain
   logic [15:0]      sh_q;
   logic [CNT_W-1:0] cnt_q;
   logic             tog_q;
   logic             fall_seen_q;
   logic [15:0]      diag_q;

   // Cleared by the select itself, since the link clock stops between frames
   always_ff @(negedge sclk_i or posedge chip_select_n_i) begin
      if (chip_select_n_i) begin
         fall_seen_q <= 1'b0;
      end else begin
         fall_seen_q <= 1'b1;
      end
   end

   // First falling edge of a frame loads the frozen diagnosis word
   always_ff @(negedge sclk_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         sh_q  <= FRAME_RST;
         cnt_q <= '0;
         tog_q <= 1'b0;
      end else if (!chip_select_n_i) begin
         if (!fall_seen_q) begin
            sh_q  <= {diag_q[14:0], serial_in_i};
            cnt_q <= 5'h01;
            tog_q <= ~tog_q;
         end else begin
            sh_q  <= {sh_q[14:0], serial_in_i};
            if (cnt_q != FRAME_BITS) begin
               cnt_q <= cnt_q + 5'h01;
            end
         end
      end
   end

   // Input synchronisers
   logic [AW-1:0] async_w;
   logic [AW-1:0] sync1_q;
   logic [AW-1:0] sync2_q;
   logic          inh_s;
   logic          csn_s;
   logic          tog_s;
   logic [1:0]    sd_s;
   logic          psf_s;
   logic [NUM_SENS-1:0] warn_s;

   assign async_w = {inhibit_input_i, chip_select_n_i, tog_q, temp_sd_grp2_i,
                     temp_sd_grp1_i, supply_fail_i, temp_warn_i};

   // Idle levels keep a false select edge from following reset
   localparam logic [AW-1:0] SYNC_IDLE = {1'b0, 1'b1, {(AW-2){1'b0}}};

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         sync1_q <= SYNC_IDLE;
         sync2_q <= SYNC_IDLE;
      end else begin
         sync1_q <= async_w;
         sync2_q <= sync1_q;
      end
   end

   assign {inh_s, csn_s, tog_s, sd_s, psf_s, warn_s} = sync2_q;

   // Daisy chain: after the status word, received bits leave in order
   assign serial_out_o    = fall_seen_q ? sh_q[15] : diag_q[15];
   assign serial_out_oe_o = ~chip_select_n_i & inh_s;

   // Frame commit
   logic        csn_prev_q;
   logic        seen_tog_q;
   logic        commit;
   pdsd_frame_t frame;

   // Shift path is quiet while select is high, so it crosses as a stable word
   assign frame  = pdsd_frame_t'(sh_q);
   assign commit = csn_s & ~csn_prev_q & (tog_s != seen_tog_q)
                   & (cnt_q == FRAME_BITS) & inh_s;

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         csn_prev_q <= 1'b1;
         seen_tog_q <= 1'b0;
      end else begin
         csn_prev_q <= csn_s;
         if (csn_s & ~csn_prev_q) begin
            seen_tog_q <= tog_s;
         end
      end
   end

   // Control words
   logic [DATA_W-1:0] ctrl_q [4];
   logic [2:0]        sense_q;

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         for (int i = 0; i < 4; i++) begin
            ctrl_q[i] <= CTRL_RST;
         end
         sense_q <= SENSE_RST;
      end else if (!inh_s) begin
         for (int i = 0; i < 4; i++) begin
            ctrl_q[i] <= CTRL_RST;
         end
         sense_q <= SENSE_RST;
      end else if (commit) begin
         ctrl_q[frame.addr] <= frame.data;
         sense_q            <= frame.sense;
      end
   end

   // Thermal and supply flags
   logic [1:0] tsd_q;
   logic       tw_q;
   logic       psf_q;

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         tsd_q <= 2'h0;
      end else if (!inh_s) begin
         tsd_q <= 2'h0;
      end else begin
         // A new report wins over a clear in the same cycle
         tsd_q <= sd_s | (tsd_q & ~{2{commit & frame.status_reset_request}});
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         tw_q <= 1'b0;
      end else begin
         tw_q <= inh_s & (|warn_s);
      end
   end

   // Not held: follows the supply monitor
   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         psf_q <= 1'b0;
      end else begin
         psf_q <= inh_s & psf_s;
      end
   end

   // Diagnosis word, frozen while a frame is running
   logic [FRAME_W-1:0] diag_w;

   always_comb begin
      diag_w            = FRAME_RST;
      diag_w[DIAG_TW]   = tw_q;
      diag_w[DIAG_TSD1] = tsd_q[0];
      diag_w[DIAG_TSD2] = tsd_q[1];
      diag_w[DIAG_PSF]  = psf_q;
   end

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         diag_q <= FRAME_RST;
      end else if (csn_s) begin
         diag_q <= diag_w;
      end
   end

   // Output mapping
   wire pdsd_drive_t drv_w;
   logic [10:0]      grp_on;

   assign grp_on = {{8{~tsd_q[1]}}, {3{~tsd_q[0]}}};

   genvar k;
   generate
      for (k = 1; k <= 3; k++) begin : g_bridge
         assign drv_w.ls[k]   = ctrl_q[ADDR_LOCK][POS_LS_BASE-2*(k-1)] & grp_on[k-1];
         assign drv_w.hs[k]   = ctrl_q[ADDR_LOCK][POS_HS_BASE-2*(k-1)] & grp_on[k-1];
         assign drv_w.ls[k+3] = ctrl_q[ADDR_LAMP][POS_LS_BASE-2*(k-1)] & grp_on[k+2];
         assign drv_w.hs[k+3] = ctrl_q[ADDR_LAMP][POS_HS_BASE-2*(k-1)] & grp_on[k+2];
      end
      for (k = 8; k <= 11; k++) begin : g_lamp
         assign drv_w.hs[k]   = ctrl_q[ADDR_LAMP][POS_HS8-(k-8)] & grp_on[k-1];
      end
   endgenerate
   assign drv_w.hs[7] = ctrl_q[ADDR_LOCK][POS_HS7] & grp_on[6];

   logic        active_q;
   pdsd_drive_t drive_q;
   pdsd_sense_t sense_rt_q;

   // Supply fault turns every stage off without being held
   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         drive_q <= '0;
      end else begin
         drive_q <= (inh_s & ~psf_q) ? drv_w : '0;
      end
   end

   // Low keeps the stages in high impedance
   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         active_q <= 1'b0;
      end else begin
         active_q <= inh_s;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         sense_rt_q <= '0;
      end else begin
         sense_rt_q <= sense_decode(sense_q);
      end
   end

   assign drive_o                 = drive_q;
   assign outputs_active_o        = active_q;
   assign sense_route_o           = sense_rt_q;
   assign thermal_warning_flag_o  = tw_q;
   assign thermal_shutdown_flag_o = tsd_q;
   assign supply_fail_flag_o      = psf_q;

endmodule

// *** pkg/pdsd_pkg.sv ***
// Shared constants and types of the power driver serial control and diagnosis block
package pdsd_pkg;
   localparam int          FRAME_W     = 16;
   localparam int          DATA_W      = 10;
   localparam int          CNT_W       = 5;
   localparam logic [4:0]  FRAME_BITS  = 5'h10;
   // Register address of each control word
   localparam logic [1:0]  ADDR_LOCK   = 2'h0;
   localparam logic [1:0]  ADDR_PWM1   = 2'h1;
   localparam logic [1:0]  ADDR_LAMP   = 2'h2;
   localparam logic [1:0]  ADDR_PWM2   = 2'h3;
   // Positions inside the addressable data field
   localparam int          POS_LS_BASE = 9;
   localparam int          POS_HS_BASE = 8;
   localparam int          POS_HS7     = 3;
   localparam int          POS_HS8     = 3;
   // Diagnosis word layout
   localparam int          DIAG_TW     = 0;
   localparam int          DIAG_TSD1   = 1;
   localparam int          DIAG_TSD2   = 2;
   localparam int          DIAG_PSF    = 7;
   // Sense select codes
   localparam logic [2:0]  SENSE_HS1   = 3'h0;
   localparam logic [2:0]  SENSE_HS2   = 3'h1;
   localparam logic [2:0]  SENSE_HS3   = 3'h2;
   localparam logic [2:0]  SENSE_HS4   = 3'h3;
   localparam logic [2:0]  SENSE_HS7   = 3'h4;
   // Values after reset
   localparam logic [9:0]  CTRL_RST    = 10'h000;
   localparam logic [2:0]  SENSE_RST   = 3'h0;
   localparam logic [15:0] FRAME_RST   = 16'h0000;

   typedef struct packed {
      logic [9:0] data;
      logic [2:0] sense;
      logic       status_reset_request;
      logic [1:0] addr;
   } pdsd_frame_t;

   typedef struct packed {
      logic hs1;
      logic hs2;
      logic hs3;
      logic hs4;
      logic hs7;
   } pdsd_sense_t;

   typedef struct packed {
      logic [6:1]  ls;
      logic [11:1] hs;
   } pdsd_drive_t;
endpackage

// *** bench/pdsd_spi_diag_checker.sv ***
// Port-level checks of the serial control and diagnosis block
`timescale 1ns/100ps
module pdsd_spi_diag_checker
   import pdsd_pkg::*;
#(
   parameter int NUM_SENS = 4
) (
   input wire logic                clk_sys_i,
   input wire logic                rst_b_i,
   input wire logic                chip_select_n_i,
   input wire logic                serial_out_oe_o,
   input wire logic                inhibit_input_i,
   input wire logic [NUM_SENS-1:0] temp_warn_i,
   input wire logic                temp_sd_grp1_i,
   input wire logic                temp_sd_grp2_i,
   input wire logic                supply_fail_i,
   input wire pdsd_drive_t         drive_o,
   input wire logic                outputs_active_o,
   input wire pdsd_sense_t         sense_route_o,
   input wire logic                thermal_warning_flag_o,
   input wire logic [1:0]          thermal_shutdown_flag_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   // Cycles since the last event allowed to move control, the shutdown flags or the supply flag
   logic [3:0] calm_q;
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i)
         calm_q <= 4'h0;
      else if (!chip_select_n_i || !inhibit_input_i || supply_fail_i || temp_sd_grp1_i
               || temp_sd_grp2_i)
         calm_q <= 4'h0;
      else if (calm_q != 4'hF)
         calm_q <= calm_q + 4'h1;
   end
   chk_oe_release: assert property (chip_select_n_i |-> !serial_out_oe_o)
      else $error("serial output enabled while deselected");
   chk_warn_set: assert property (
      (|temp_warn_i && inhibit_input_i)[*8] |-> thermal_warning_flag_o)
      else $error("warning flag missing");
   chk_warn_clear: assert property (
      (!(|temp_warn_i))[*8] |-> !thermal_warning_flag_o)
      else $error("warning flag held");
   chk_sd_set: assert property (
      (temp_sd_grp1_i && inhibit_input_i)[*8] |-> thermal_shutdown_flag_o[0])
      else $error("group one shutdown flag missing");
   chk_sd_group2: assert property (
      (temp_sd_grp2_i && inhibit_input_i)[*8] |-> thermal_shutdown_flag_o[1])
      else $error("group two shutdown flag missing");
   chk_grp1_off: assert property (
      thermal_shutdown_flag_o[0][*2] |-> {drive_o.ls[3:1], drive_o.hs[3:1]} == 6'h00)
      else $error("group one still driven");
   chk_grp2_off: assert property (
      thermal_shutdown_flag_o[1][*2] |-> {drive_o.ls[6:4], drive_o.hs[11:4]} == 11'h000)
      else $error("group two still driven");
   chk_sd_held: assert property ($fell(|thermal_shutdown_flag_o) |-> calm_q < 4'hA)
      else $error("shutdown flag dropped without request");
   chk_sd_latched: assert property (
      (thermal_shutdown_flag_o[0] && chip_select_n_i && inhibit_input_i)[*8]
      |=> thermal_shutdown_flag_o[0])
      else $error("group one shutdown flag not held");
   chk_ctrl_hold: assert property (
      calm_q > 4'hA |-> $stable(drive_o) && $stable(sense_route_o))
      else $error("control changed without a frame");
   chk_inhibit_off: assert property (
      (!inhibit_input_i)[*5] |-> !serial_out_oe_o && drive_o == '0 && !outputs_active_o)
      else $error("inhibit did not stop the block");
   cover property ($rose(thermal_shutdown_flag_o[0]));
   cover property ($fell(chip_select_n_i) ##1 serial_out_oe_o);
   cover property (sense_route_o.hs7);
endmodule
bind pdsd_spi_diag pdsd_spi_diag_checker #(.NUM_SENS(NUM_SENS)) pdsd_spi_diag_checker_i (.*);

// *** bench/pdsd_host_model.sv ***
// Host serial master: link clock runs only inside frames
`timescale 1ns/100ps
module pdsd_host_model (
   output logic      sclk_o,
   output logic      csn_o,
   output logic      sdi_o,
   input  wire logic sdo_i,
   input  wire logic sdo_oe_i
);
   initial begin
      sclk_o = 1'b0;
      csn_o  = 1'b1;
      sdi_o  = 1'b0;
   end
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      #37 csn_o = 1'b0;
      #80;
      for (int i = n - 1; i >= 0; i--) begin
         sclk_o = 1'b1;
         sdi_o  = w[i];
         #80 r = {r[14:0], sdo_oe_i ? sdo_i : 1'bx};
         sclk_o = 1'b0;
         #80;
      end
      csn_o = 1'b1;
      // Released line shows the inverse, never a stale bit
      sdi_o = ~sdi_o;
   endtask
endmodule

// *** bench/testbench.sv ***
// Self-checking bench of the serial control and diagnosis block
`timescale 1ns/100ps
module testbench;
   import pdsd_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic        inhibit_input       = 1'b1;
   logic        supply_fail_flag       = 1'b0;
   logic [1:0]  sd        = 2'h0;
   logic [3:0]  warn      = 4'h0;
   logic        sclk, chip_select_n, sdi, sdo, oe, tw, sf, act;
   logic [1:0]  thermal_shutdown_flag;
   pdsd_drive_t drv;
   pdsd_sense_t sns;
   logic [15:0] f0 = 16'h0000, f2 = 16'h0002, w, rx;
   int          failures = 0, samples_checked = 0, cyc = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   pdsd_spi_diag #(.NUM_SENS(4)) pdsd_spi_diag_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
      .sclk_i(sclk), .chip_select_n_i(chip_select_n), .serial_in_i(sdi), .serial_out_o(sdo),
      .serial_out_oe_o(oe), .inhibit_input_i(inhibit_input), .temp_warn_i(warn), .temp_sd_grp1_i(sd[0]),
      .temp_sd_grp2_i(sd[1]), .supply_fail_i(supply_fail_flag), .drive_o(drv), .outputs_active_o(act),
      .sense_route_o(sns), .thermal_warning_flag_o(tw), .thermal_shutdown_flag_o(thermal_shutdown_flag),
      .supply_fail_flag_o(sf));
   pdsd_host_model pdsd_host_model_i (.sclk_o(sclk), .csn_o(chip_select_n), .sdi_o(sdi), .sdo_i(sdo),
      .sdo_oe_i(oe));
   function automatic pdsd_drive_t exp_drv(input logic [15:0] a, b, input logic [1:0] g);
      pdsd_drive_t d;
      d.ls = {b[11], b[13], b[15], a[11], a[13], a[15]};
      d.hs = {b[6], b[7], b[8], b[9], a[9], b[10], b[12], b[14], a[10], a[12], a[14]};
      if (g[0]) d.ls[3:1] = 3'h0;
      if (g[0]) d.hs[3:1] = 3'h0;
      if (g[1]) d.ls[6:4] = 3'h0;
      if (g[1]) d.hs[11:4] = 8'h00;
      return d;
   endfunction
   function automatic logic [4:0] exp_sns(input logic [2:0] c);
      return (c < 3'h5) ? (5'h10 >> c) : 5'h00;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic frame(input logic [15:0] f, input int n);
      pdsd_host_model_i.xfer(f, n, rx);
      repeat (8) @(posedge clk_sys_i);
      if (n == 16 && f[1:0] == ADDR_LOCK) f0 = f;
      if (n == 16 && f[1:0] == ADDR_LAMP) f2 = f;
   endtask
   task automatic pins(input logic [3:0] t, input logic [1:0] s, input logic p, i);
      @(posedge clk_sys_i);
      warn <= t;
      sd   <= s;
      supply_fail_flag  <= p;
      inhibit_input  <= i;
      repeat (8) @(posedge clk_sys_i);
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         failures++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'hF04D3804));
      repeat (3) @(posedge clk_sys_i);
      check(drv, 0);
      check(act, 0);
      rst_b_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      for (int k = 0; k < 24; k++) begin
         w = (k == 0) ? 16'hFFC2 : (k == 1) ? 16'hFE00 : 16'($urandom);
         w[5:3] = k[2:0];
         if (w[1:0] == ADDR_LOCK) w[8:6] = 3'h0;
         frame(w, 16);
         check(drv, exp_drv(f0, f2, 2'h0));
         check(sns, exp_sns(w[5:3]));
         check(oe, 0);
      end
      check(act, 1);
      $display("test control words finished");
      pins(4'h5, 2'h1, 1'b1, 1'b1);
      check(tw, 1);
      check(sf, 1);
      frame(f2, 16);
      check(rx, 16'h0083);
      check(drv, 0);
      pins(4'h0, 2'h0, 1'b0, 1'b1);
      check(tw, 0);
      check(sf, 0);
      check(thermal_shutdown_flag, 2'h1);
      check(drv, exp_drv(f0, f2, 2'h1));
      pins(4'h0, 2'h2, 1'b0, 1'b1);
      pins(4'h0, 2'h0, 1'b0, 1'b1);
      check(thermal_shutdown_flag, 2'h3);
      frame(f0 | 16'h0004, 16);
      check(rx, 16'h0006);
      check(thermal_shutdown_flag, 2'h0);
      check(drv, exp_drv(f0, f2, 2'h0));
      frame(~f0 & 16'hFE00, 15);
      check(drv, exp_drv(f0, f2, 2'h0));
      check(sns, exp_sns(f0[5:3]));
      $display("test diagnosis and shutdown finished");
      pins(4'hF, 2'h3, 1'b0, 1'b0);
      check(act, 0);
      check(tw, 0);
      frame(16'hFE00, 16);
      check(drv, 0);
      check(thermal_shutdown_flag, 2'h0);
      check(sns, exp_sns(SENSE_RST));
      pins(4'h0, 2'h0, 1'b0, 1'b1);
      f0 = 16'h0000;
      f2 = 16'h0002;
      check(drv, 0);
      check(act, 1);
      frame(16'hFE00, 16);
      check(drv, exp_drv(f0, f2, 2'h0));
      $display("test inhibit finished");
      give_verdict();
   end
endmodule
